//--- tpt_pkg.sv
// Purpose: constants and types for the two-point hysteresis thermostat
// Assumes: 100 MHz system clock, AXI4-Lite register access, temperatures as signed 16-bit counts
// Notes:   all offsets are byte addresses of aligned 32-bit words

`default_nettype none

package tpt_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam longint unsigned CLK_HZ        = 64'd100_000_000;
  localparam longint unsigned EVAL_PERIOD_S = 64'd30;
  localparam logic [31:0]     EVAL_CYCLES   = 32'(EVAL_PERIOD_S * CLK_HZ);

  // ---------------------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_TEMP      = 8'h04;
  localparam logic [7:0] REG_HEAT_SP   = 8'h08;
  localparam logic [7:0] REG_COOL_SP   = 8'h0c;
  localparam logic [7:0] REG_HYST_HEAT = 8'h10;
  localparam logic [7:0] REG_HYST_COOL = 8'h14;
  localparam logic [7:0] REG_STAGE_OFS = 8'h18;
  localparam logic [7:0] REG_STATUS    = 8'h1c;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h24;

  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_OBJ_BIT  = 2;
  localparam int CTRL_INV_BIT  = 3;
  localparam int CTRL_ADD_BIT  = 4;

  // hysteresis fields: lower span in [7:0], upper span in [15:8]
  localparam int HYST_LO_LSB = 0;
  localparam int HYST_HI_LSB = 8;

  // status / irq bit positions, except that the status read has heat add at bit 1 and cool at bit 2
  localparam int ST_HEAT     = 0;
  localparam int ST_COOL     = 1;
  localparam int ST_HEAT_ADD = 2;
  localparam int ST_COOL_ADD = 3;
  localparam int ST_HEAT_MSG = 4;
  localparam int ST_COOL_MSG = 5;
  localparam int ST_COOL_SEL = 6;
  localparam int IRQ_HEAT_CHG = 0;
  localparam int IRQ_COOL_CHG = 1;
  localparam int IRQ_EVAL     = 2;
  localparam int IRQ_W        = 3;

  // reset values
  localparam logic [15:0] RST_HEAT_SP = 16'h0834;
  localparam logic [15:0] RST_COOL_SP = 16'h0960;
  localparam logic [15:0] RST_HYST    = 16'h3232;
  localparam logic [7:0]  RST_OFS     = 8'h64;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [1:0] {
    TPT_MODE_HEAT,
    TPT_MODE_COOL,
    TPT_MODE_MIXED
  } tpt_mode_t;

  typedef logic signed [17:0] tpt_lvl_t;

  function automatic tpt_lvl_t tpt_ext(input logic [15:0] v);
    tpt_ext = tpt_lvl_t'(signed'(v));
  endfunction : tpt_ext

  function automatic tpt_lvl_t tpt_span(input logic [7:0] v);
    tpt_span = tpt_lvl_t'({10'h000, v});
  endfunction : tpt_span

endpackage : tpt_pkg

`default_nettype wire

//--- tpt_stage.sv
// Purpose: one two-point switching stage with hysteresis
// Assumes: limits already include setpoint, hysteresis and stage offset
// Notes:   state only moves on the evaluation tick

`default_nettype none

module tpt_stage (
  // clock and reset
  input  wire logic          i_sys_clk,
  input  wire logic          i_sys_rst,
  // evaluation
  input  wire logic          i_tick,
  input  wire logic          i_enable,
  input  wire logic          i_heat,
  input  wire tpt_pkg::tpt_lvl_t i_temp,
  input  wire tpt_pkg::tpt_lvl_t i_on_lim,
  input  wire tpt_pkg::tpt_lvl_t i_off_lim,
  // result
  output logic               o_next,
  output logic               o_on
);
  import tpt_pkg::*;

  logic on_q;

  // heating switches on below, cooling above; between limits the state holds
  always_comb begin
    o_next = on_q;
    if (!i_enable) begin
      o_next = 1'b0;
    end else if (i_heat) begin
      if (i_temp < i_on_lim) begin
        o_next = 1'b1;
      end else if (i_temp > i_off_lim) begin
        o_next = 1'b0;
      end
    end else begin
      if (i_temp > i_on_lim) begin
        o_next = 1'b1;
      end else if (i_temp < i_off_lim) begin
        o_next = 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      on_q <= 1'b0;
    end else if (i_tick) begin
      on_q <= o_next;
    end
  end

  assign o_on = on_q;

endmodule : tpt_stage

`default_nettype wire

//--- tpt_thermostat.sv
// Purpose: two-point hysteresis room thermostat with AXI4-Lite registers
// Assumes: software writes the measured temperature into the temp register
// Notes:   the change-over input is asynchronous and is synchronised

`default_nettype none

module tpt_thermostat #(
  parameter logic [31:0] P_EVAL_CYCLES = tpt_pkg::EVAL_CYCLES
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // axi4-lite write address / data / response
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  // external change-over object, high selects cooling
  input  wire logic        i_changeover_cool,
  // actuator commands and messages
  output logic             o_heat_cmd,
  output logic             o_cool_cmd,
  output logic             o_heat_add_cmd,
  output logic             o_cool_add_cmd,
  output logic             o_heat_msg,
  output logic             o_cool_msg,
  output logic             o_irq
);
  import tpt_pkg::*;

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  logic [4:0]        ctrl_q;
  logic [15:0]       temp_q;
  logic [15:0]       heat_sp_q;
  logic [15:0]       cool_sp_q;
  logic [15:0]       hyst_heat_q;
  logic [15:0]       hyst_cool_q;
  logic [7:0]        ofs_q;
  logic [IRQ_W-1:0]  irq_stat_q;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [31:0]       tick_cnt_q;
  logic              tick_q;
  logic              co_meta_q;
  logic              co_sync_q;
  logic              cool_sel_q;
  logic [3:0]        cmd_q;
  logic              heat_msg_q;
  logic              cool_msg_q;

  tpt_mode_t         mode;
  logic              obj_co;
  logic              inv;
  logic              add_en;
  logic              mixed_auto;
  logic              cool_sel_d;
  logic              heat_act;
  logic              cool_act;
  tpt_lvl_t          temp_l;
  tpt_lvl_t          heat_sp_l;
  tpt_lvl_t          cool_sp_l;
  tpt_lvl_t          on_lim  [4];
  tpt_lvl_t          off_lim [4];
  logic [3:0]        st_en;
  logic [3:0]        st_next;
  logic [3:0]        st_on;
  logic [3:0]        cmd_d;

  assign mode       = tpt_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign obj_co     = ctrl_q[CTRL_OBJ_BIT];
  assign inv        = ctrl_q[CTRL_INV_BIT];
  assign add_en     = ctrl_q[CTRL_ADD_BIT];
  assign mixed_auto = (mode == TPT_MODE_MIXED) && !obj_co;
  assign temp_l     = tpt_ext(temp_q);
  assign heat_sp_l  = tpt_ext(heat_sp_q);
  assign cool_sp_l  = tpt_ext(cool_sp_q);

  // ---------------------------------------------------------------------------
  // evaluation tick
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == P_EVAL_CYCLES - 32'h0000_0001) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // change-over selection
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      co_meta_q <= 1'b0;
      co_sync_q <= 1'b0;
    end else begin
      co_meta_q <= i_changeover_cool;
      co_sync_q <= co_meta_q;
    end
  end

  // automatic selection keeps the last side while inside the deadband
  always_comb begin
    cool_sel_d = cool_sel_q;
    if (obj_co) begin
      cool_sel_d = co_sync_q;
    end else if (temp_l < heat_sp_l) begin
      cool_sel_d = 1'b0;
    end else if (temp_l > cool_sp_l) begin
      cool_sel_d = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cool_sel_q <= 1'b0;
    end else if (tick_q) begin
      cool_sel_q <= cool_sel_d;
    end
  end

  assign heat_act = (mode == TPT_MODE_HEAT) || ((mode == TPT_MODE_MIXED) && !cool_sel_d);
  assign cool_act = (mode == TPT_MODE_COOL) || ((mode == TPT_MODE_MIXED) && cool_sel_d);

  // ---------------------------------------------------------------------------
  // stage limits: 0 heat, 1 heat add, 2 cool, 3 cool add
  // ---------------------------------------------------------------------------
  always_comb begin
    tpt_lvl_t sh;
    tpt_lvl_t sc;
    sh = heat_sp_l;
    sc = cool_sp_l;
    for (int k = 0; k < 2; k++) begin
      sh = (k == 1) ? heat_sp_l - tpt_span(ofs_q) : heat_sp_l;
      sc = (k == 1) ? cool_sp_l + tpt_span(ofs_q) : cool_sp_l;
      on_lim[k]    = sh - tpt_span(hyst_heat_q[HYST_LO_LSB +: 8]);
      off_lim[k]   = mixed_auto ? sh : sh + tpt_span(hyst_heat_q[HYST_HI_LSB +: 8]);
      on_lim[k+2]  = sc + tpt_span(hyst_cool_q[HYST_HI_LSB +: 8]);
      off_lim[k+2] = mixed_auto ? sc : sc - tpt_span(hyst_cool_q[HYST_LO_LSB +: 8]);
    end
  end

  // the deadband only matters through the setpoint-based off limits, so an
  // external change-over may keep a stage on inside it
  assign st_en = {cool_act && add_en, cool_act, heat_act && add_en, heat_act};

  for (genvar g = 0; g < 4; g++) begin : g_stage
    tpt_stage u_stage (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .i_tick    (tick_q),
      .i_enable  (st_en[g]),
      .i_heat    (g < 2),
      .i_temp    (temp_l),
      .i_on_lim  (on_lim[g]),
      .i_off_lim (off_lim[g]),
      .o_next    (st_next[g]),
      .o_on      (st_on[g])
    );
  end

  // ---------------------------------------------------------------------------
  // command and message outputs
  // ---------------------------------------------------------------------------
  assign cmd_d = st_next ^ {4{inv}};

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cmd_q <= 4'h0;
    end else if (tick_q) begin
      cmd_q <= cmd_d;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      heat_msg_q <= 1'b0;
      cool_msg_q <= 1'b0;
    end else if (tick_q) begin
      heat_msg_q <= heat_act && (temp_l < heat_sp_l);
      cool_msg_q <= cool_act && (temp_l > cool_sp_l);
    end
  end

  assign o_heat_cmd     = cmd_q[0];
  assign o_heat_add_cmd = cmd_q[1];
  assign o_cool_cmd     = cmd_q[2];
  assign o_cool_add_cmd = cmd_q[3];
  assign o_heat_msg     = heat_msg_q;
  assign o_cool_msg     = cool_msg_q;

  // ---------------------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------------------
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic        wr_go;
  logic        wr_hit;
  logic [31:0] wr_mask;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  assign o_s_axi_awready = !aw_have_q && !bvalid_q;
  assign o_s_axi_wready  = !w_have_q && !bvalid_q;
  assign o_s_axi_arready = !rvalid_q;
  assign wr_go           = aw_have_q && w_have_q && !bvalid_q;
  assign wr_mask         = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a[1:0] == 2'b00) && (a <= REG_IRQ_MASK);
  endfunction : reg_mapped

  assign wr_hit = reg_mapped(awaddr_q);

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= i_s_axi_wdata;
        wstrb_q  <= i_s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid_q && i_s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp  = bresp_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctrl_q      <= 5'h00;
      temp_q      <= 16'h0000;
      heat_sp_q   <= RST_HEAT_SP;
      cool_sp_q   <= RST_COOL_SP;
      hyst_heat_q <= RST_HYST;
      hyst_cool_q <= RST_HYST;
      ofs_q       <= RST_OFS;
      irq_mask_q  <= '0;
    end else if (wr_go) begin
      case (awaddr_q)
        REG_CTRL:      ctrl_q      <= 5'(merge({27'h0, ctrl_q}, wdata_q, wr_mask));
        REG_TEMP:      temp_q      <= 16'(merge({16'h0, temp_q}, wdata_q, wr_mask));
        REG_HEAT_SP:   heat_sp_q   <= 16'(merge({16'h0, heat_sp_q}, wdata_q, wr_mask));
        REG_COOL_SP:   cool_sp_q   <= 16'(merge({16'h0, cool_sp_q}, wdata_q, wr_mask));
        REG_HYST_HEAT: hyst_heat_q <= 16'(merge({16'h0, hyst_heat_q}, wdata_q, wr_mask));
        REG_HYST_COOL: hyst_cool_q <= 16'(merge({16'h0, hyst_cool_q}, wdata_q, wr_mask));
        REG_STAGE_OFS: ofs_q       <= 8'(merge({24'h0, ofs_q}, wdata_q, wr_mask));
        REG_IRQ_MASK:  irq_mask_q  <= IRQ_W'(merge({29'h0, irq_mask_q}, wdata_q, wr_mask));
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // interrupts: sticky, write one to clear, a new event wins over the clear
  // ---------------------------------------------------------------------------
  assign irq_set[IRQ_HEAT_CHG] = tick_q && (cmd_d[0] != cmd_q[0]);
  assign irq_set[IRQ_COOL_CHG] = tick_q && (cmd_d[2] != cmd_q[2]);
  assign irq_set[IRQ_EVAL]     = tick_q;
  assign irq_clr = (wr_go && awaddr_q == REG_IRQ_STAT) ? (wdata_q[IRQ_W-1:0] & wr_mask[IRQ_W-1:0]) : '0;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= reg_mapped(i_s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      case (i_s_axi_araddr)
        REG_CTRL:      rdata_q <= {27'h0, ctrl_q};
        REG_TEMP:      rdata_q <= {16'h0, temp_q};
        REG_HEAT_SP:   rdata_q <= {16'h0, heat_sp_q};
        REG_COOL_SP:   rdata_q <= {16'h0, cool_sp_q};
        REG_HYST_HEAT: rdata_q <= {16'h0, hyst_heat_q};
        REG_HYST_COOL: rdata_q <= {16'h0, hyst_cool_q};
        REG_STAGE_OFS: rdata_q <= {24'h0, ofs_q};
        REG_STATUS:    rdata_q <= {25'h0, cool_sel_q, cool_msg_q, heat_msg_q, cmd_q[3], cmd_q[2], cmd_q[1], cmd_q[0]};
        REG_IRQ_STAT:  rdata_q <= {29'h0, irq_stat_q};
        REG_IRQ_MASK:  rdata_q <= {29'h0, irq_mask_q};
        default:       rdata_q <= 32'h0000_0000;
      endcase
    end else if (rvalid_q && i_s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rresp  = rresp_q;
  assign o_s_axi_rdata  = rdata_q;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_heat_low;
    tick_q && (mode == TPT_MODE_HEAT) && !inv && (temp_l < on_lim[0]);
  endsequence

  sequence s_cool_high;
    tick_q && (mode == TPT_MODE_COOL) && !inv && (temp_l > on_lim[2]);
  endsequence

  property p_tick_spacing;
    tick_q |=> !tick_q [*2];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("evaluation ticks too close");

  property p_cmd_hold;
    !tick_q |=> $stable(cmd_q);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command changed between evaluations");

  property p_cmd_cause;
    $changed(o_heat_cmd) |-> $past(tick_q);
  endproperty
  a_cmd_cause: assert property (p_cmd_cause) else $error("heat command moved without tick");

  property p_heat_on;
    s_heat_low |=> o_heat_cmd;
  endproperty
  a_heat_on: assert property (p_heat_on) else $error("heating not on below lower limit");

  property p_cool_on;
    s_cool_high |=> o_cool_cmd;
  endproperty
  a_cool_on: assert property (p_cool_on) else $error("cooling not on above upper limit");

  property p_auto_heat_off;
    tick_q && mixed_auto && !inv && (temp_l > heat_sp_l) |=> !o_heat_cmd;
  endproperty
  a_auto_heat_off: assert property (p_auto_heat_off) else $error("heating on above setpoint in auto mode");

  property p_auto_cool_off;
    tick_q && mixed_auto && !inv && (temp_l < cool_sp_l) |=> !o_cool_cmd;
  endproperty
  a_auto_cool_off: assert property (p_auto_cool_off) else $error("cooling on below setpoint in auto mode");

  property p_heat_msg;
    tick_q && heat_act && (temp_l < heat_sp_l) |=> o_heat_msg ##1 (o_heat_msg || $past(tick_q));
  endproperty
  a_heat_msg: assert property (p_heat_msg) else $error("heat message missing below setpoint");

  property p_reset_off;
    disable iff (1'b0) i_sys_rst |=> (cmd_q == 4'h0);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("command not off after reset");

endmodule : tpt_thermostat

`default_nettype wire

//--- tpt_actuator.sv
// Purpose: switching actuator model driving heating and cooling valves
// Assumes: one telegram per command change, no valve travel time
// Notes:   valves follow the commands one clock later
`default_nettype none
module tpt_actuator (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  // switch telegrams
  input  wire logic i_heat_cmd,
  input  wire logic i_cool_cmd,
  // valve positions
  output logic      o_heat_valve,
  output logic      o_cool_valve
);
  timeunit 1ns;
  timeprecision 1ps;
  // closed after reset, so a stuck command shows as a mismatch
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_heat_valve <= 1'b0;
      o_cool_valve <= 1'b0;
    end else begin
      o_heat_valve <= i_heat_cmd;
      o_cool_valve <= i_cool_cmd;
    end
  end
endmodule : tpt_actuator
`default_nettype wire

//--- tpt_thermostat_test.sv
// Purpose: self-checking bench for the thermostat
// Assumes: evaluation period shortened to 20 cycles
// Notes:   each step writes right after a tick, so the writes land before the next one
`default_nettype none
module tpt_thermostat_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tpt_pkg::*;
  // ------
  // signals
  // ------
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, co;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_q;
  logic [1:0]  bresp, rresp, rs_q, bs_q;
  logic        awready, wready, bvalid, arready, rvalid, irq, vh, vc;
  logic        hc, cc, hac, cac, hm, cm;
  logic [5:0]  outs, prev;
  int          error_cnt = 0, checks = 0, cyc = 0;
  // ctrl, change-over and {cool msg, heat msg, cool add, heat add, cool, heat}, temperature
  logic [31:0] tbl [23] = '{32'h00000900, 32'h00110800, 32'h00010860, 32'h00000870, 32'h01200990,
    32'h012209a0, 32'h01020930, 32'h01000920, 32'h02110800, 32'h02000840, 32'h02000900,
    32'h022209a0, 32'h02000950, 32'h06110800, 32'h06010860, 32'h06a209a0, 32'h06820940,
    32'h10000900, 32'h101107c0, 32'h10150790, 32'h101507e0, 32'h10110810, 32'h080f0900};
  assign outs = {cm, hm, cac, hac, cc, hc};
  tpt_thermostat #(.P_EVAL_CYCLES(32'd20)) tpt_thermostat_i (.i_sys_clk(clk), .i_sys_rst(rst),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .i_changeover_cool(co), .o_heat_cmd(hc), .o_cool_cmd(cc),
    .o_heat_add_cmd(hac), .o_cool_add_cmd(cac), .o_heat_msg(hm), .o_cool_msg(cm), .o_irq(irq));
  tpt_actuator tpt_actuator_i (.i_sys_clk(clk), .i_sys_rst(rst), .i_heat_cmd(hc), .i_cool_cmd(cc),
    .o_heat_valve(vh), .o_cool_valve(vc));
  // ------
  // tasks
  // ------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // handshakes judged at the falling edge, so ready is settled before the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hit, w_hit, b_hit;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      b_hit = bvalid;
      if (bvalid) bs_q = bresp;
      @(posedge clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end while (!b_hit);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ar_hit, r_hit;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ar_hit = arvalid && arready;
      r_hit = rvalid;
      if (rvalid) begin
        rd_q = rdata;
        rs_q = rresp;
      end
      @(posedge clk);
      if (ar_hit) arvalid <= 1'b0;
    end while (!r_hit);
    rready <= 1'b0;
  endtask : rd
  // the evaluation-done interrupt marks each tick; returns at a falling edge
  task automatic tick;
    for (int n = 0; n < 60 && irq !== 1'b1; n++) @(negedge clk);
    chk("tick", irq, 1'b1);
  endtask : tick
  task automatic close_out;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  // ------
  // run
  // ------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, co} = 7'h40;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wr(REG_TEMP, 32'h900);
    chk("cmd_rst", outs, 6'h00);
    chk("bresp", bs_q, RESP_OKAY);
    rd(REG_HEAT_SP);
    chk("heat_sp", rd_q, 32'h834);
    rd(8'h40);
    chk("decerr", rs_q, RESP_DECERR);
    chk("decerr_data", rd_q, 32'h0);
    wr(8'h40, 32'h0);
    chk("wr_decerr", bs_q, RESP_DECERR);
    repeat (25) @(posedge clk);
    chk("irq_masked", irq, 1'b0);
    wr(REG_IRQ_MASK, 32'h4);
    chk("irq_unmasked", irq, 1'b1);
    wr(REG_IRQ_STAT, 32'h7);
    tick;
    prev = 6'h00;
    foreach (tbl[k]) begin
      @(posedge clk);
      co <= tbl[k][23];
      wr(REG_CTRL, {24'h0, tbl[k][31:24]});
      wr(REG_TEMP, {16'h0, tbl[k][15:0]});
      wr(REG_IRQ_STAT, 32'h7);
      @(negedge clk);
      chk("hold", outs, prev);
      chk("valve", {vc, vh}, prev[1:0]);
      tick;
      chk("cmd", outs, tbl[k][21:16]);
      prev = tbl[k][21:16];
    end
    close_out();
  end
endmodule : tpt_thermostat_test
`default_nettype wire
